// ==== dax_aux.sv ====
/*
  Auxiliary functions of a vector drive control core: encoder settings,
  excitation ratio, speed-loop notch decode, torque and low-speed detect
  flags with terminal routing, and a first-order monitor output filter.
  Assumes parameters are static levels synchronous to clk_i and the
  torque and speed feedback are sampled once per control cycle.
*/
module dax_aux
  import dax_pkg::*;
(
  input wire logic clk_i, // 20 MHz control clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic [12:0] encoder_line_count_i, // Lines before x4
  input wire logic encoder_dir_sel_i, // Forward count direction
  input wire logic [6:0] excitation_ratio_i, // Percent
  input wire logic [1:0] term1_function_sel_i, // 1=flux command, 0,2,3=none
  input wire logic [4:0] notch_freq_code_i, // 0 disables
  input wire logic [1:0] notch_depth_code_i, // Depth select
  input wire logic [8:0] torque_detect_threshold_i, // Percent
  input wire logic [11:0] low_speed_threshold_i, // r/min
  input wire logic [12:0] monitor_filter_tc_i, // ms
  input wire logic [1:0] ctrl_mode_i, // dax_mode_t
  input wire logic running_i, // Drive running
  input wire logic [8:0] torque_i, // Output torque, percent
  input wire logic [11:0] speed_i, // Motor speed magnitude, r/min
  input wire logic [15:0] monitor_in_i, // Raw monitor value
  input wire logic [5:0] output_term_func_sel_a_i, // Terminal A
  input wire logic [5:0] output_term_func_sel_b_i, // Terminal B
  input wire logic [5:0] output_term_func_sel_c_i, // Terminal C
  input wire logic [5:0] output_term_func_sel_d_i, // Terminal D
  output logic [14:0] enc_counts_rev_o, // Counts per rev, x4
  output logic enc_dir_o, // Active direction setting
  output logic [6:0] flux_ratio_o, // Applied excitation, percent
  output logic flux_from_term1_o, // Flux from terminal 1
  output logic notch_en_o, // Notch active
  output logic [13:0] notch_centre_o, // Centre, 0.1 Hz
  output logic [5:0] notch_atten_db_o, // Attenuation, dB
  output logic torque_reached_flag_o, // Torque at/above threshold
  output logic slow_speed_flag_o, // Low speed detected
  output logic [N_TERMS-1:0] term_out_o, // Output terminals A..D
  output logic [15:0] analog_monitor_out_o // Filtered monitor
);

  // ****************************************************************
  // Parameter capture
  // ****************************************************************
  logic [12:0] next_enc_lines;
  logic [14:0] enc_counts, next_enc_counts;
  logic enc_dir, next_enc_dir;
  logic [6:0] flux_ratio, next_flux_ratio;
  logic flux_term1, next_flux_term1;

  always_comb
  begin
    next_enc_lines = (encoder_line_count_i > ENC_LINES_MAX) ?
                     ENC_LINES_MAX : encoder_line_count_i;
    next_enc_counts = 15'(next_enc_lines * ENC_MULT);
    next_enc_dir = encoder_dir_sel_i;
    next_flux_term1 = (term1_function_sel_i == TERM1_FLUX_CMD);
    if (next_flux_term1)
      next_flux_ratio = EXC_RATIO_DEF;
    else if (excitation_ratio_i > EXC_RATIO_MAX)
      next_flux_ratio = EXC_RATIO_MAX;
    else
      next_flux_ratio = excitation_ratio_i;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      enc_counts <= 15'(ENC_LINES_DEF * ENC_MULT);
      enc_dir <= ENC_DIR_DEF;
      flux_ratio <= EXC_RATIO_DEF;
      flux_term1 <= 1'b0;
    end
    else
    begin
      enc_counts <= next_enc_counts;
      enc_dir <= next_enc_dir;
      flux_ratio <= next_flux_ratio;
      flux_term1 <= next_flux_term1;
    end
  end

  assign enc_counts_rev_o = enc_counts;
  assign enc_dir_o = enc_dir;
  assign flux_ratio_o = flux_ratio;
  assign flux_from_term1_o = flux_term1;

  // ****************************************************************
  // Notch decode
  // ****************************************************************
  logic notch_en, next_notch_en;
  logic [13:0] notch_centre, next_notch_centre;
  logic [5:0] notch_db, next_notch_db;

  always_comb
  begin
    next_notch_en = (notch_freq_code_i != NOTCH_OFF);
    if (next_notch_en)
      next_notch_centre = 14'(NOTCH_BASE_DHZ / notch_freq_code_i);
    else
      next_notch_centre = '0;
    unique case (notch_depth_code_i)
      2'h0: next_notch_db = DEPTH_DB_0;
      2'h1: next_notch_db = DEPTH_DB_1;
      2'h2: next_notch_db = DEPTH_DB_2;
      2'h3: next_notch_db = DEPTH_DB_3;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      notch_en <= 1'b0;
      notch_centre <= '0;
      notch_db <= DEPTH_DB_0;
    end
    else
    begin
      notch_en <= next_notch_en;
      notch_centre <= next_notch_centre;
      notch_db <= next_notch_db;
    end
  end

  assign notch_en_o = notch_en;
  assign notch_centre_o = notch_centre;
  assign notch_atten_db_o = notch_db;

  // ****************************************************************
  // Control cycle tick and detect flags
  // ****************************************************************
  logic [11:0] tick_cnt, next_tick_cnt;
  logic tick;
  logic trq_flag, next_trq_flag;
  logic slow_flag, next_slow_flag;
  logic [N_TERMS-1:0] term, next_term;
  logic [5:0] sel [N_TERMS];
  logic slow_cond;

  assign tick = (tick_cnt == CTRL_LAST);
  assign sel[0] = output_term_func_sel_a_i;
  assign sel[1] = output_term_func_sel_b_i;
  assign sel[2] = output_term_func_sel_c_i;
  assign sel[3] = output_term_func_sel_d_i;

  always_comb
  begin
    next_tick_cnt = tick ? '0 : 12'(tick_cnt + 12'h001);
    next_trq_flag = trq_flag;
    next_slow_flag = slow_flag;
    if (low_speed_threshold_i == LSPD_THR_ZERO)
      slow_cond = (ctrl_mode_i == MODE_POSITION);
    else
      slow_cond = (ctrl_mode_i != MODE_VF) &&
                  (speed_i <= low_speed_threshold_i);
    if (tick)
    begin
      next_trq_flag = (torque_i >= torque_detect_threshold_i);
      next_slow_flag = running_i && slow_cond;
    end
    if (!running_i)
      next_slow_flag = 1'b0;
    for (int i = 0; i < N_TERMS; i++)
      next_term[i] = ((sel[i] == FUNC_TORQUE) && next_trq_flag) ||
                     ((sel[i] == FUNC_LOWSPD) && next_slow_flag);
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tick_cnt <= '0;
      trq_flag <= 1'b0;
      slow_flag <= 1'b0;
      term <= '0;
    end
    else
    begin
      tick_cnt <= next_tick_cnt;
      trq_flag <= next_trq_flag;
      slow_flag <= next_slow_flag;
      term <= next_term;
    end
  end

  assign torque_reached_flag_o = trq_flag;
  assign slow_speed_flag_o = slow_flag;
  assign term_out_o = term;

  // ****************************************************************
  // Monitor filter: y += (x - y) / 2^k, updated each control cycle
  // ****************************************************************
  logic [31:0] mon_acc, next_mon_acc;
  logic [3:0] mon_k;
  logic [12:0] tc_lim;

  always_comb
  begin
    tc_lim = (monitor_filter_tc_i > MON_TC_MAX) ?
             MON_TC_MAX : monitor_filter_tc_i;
    // Shift ~ log2(tc / cycle); 0.1 ms cycle -> tc_ms * 10 cycles
    mon_k = '0;
    for (int b = 0; b < 13; b++)
      if (tc_lim[b])
        mon_k = 4'((b + 4 > MON_TC_SHIFT_MAX) ? MON_TC_SHIFT_MAX : b + 4);
    next_mon_acc = mon_acc;
    if (tick)
    begin
      if (tc_lim == '0)
        next_mon_acc = {monitor_in_i, 16'h0000};
      else
        next_mon_acc = 32'($signed(mon_acc) +
          ($signed({1'b0, monitor_in_i, 16'h0000} - {1'b0, mon_acc})
           >>> mon_k));
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      mon_acc <= '0;
    else
      mon_acc <= next_mon_acc;
  end

  assign analog_monitor_out_o = mon_acc[31:16];

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_tick_hi_torque;
    tick && (torque_i >= torque_detect_threshold_i);
  endsequence

  AST_TRQ_ON: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_tick_hi_torque |=> torque_reached_flag_o)
    else $error("torque flag not set");
  AST_TRQ_OFF: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    tick && (torque_i < torque_detect_threshold_i)
    |=> !torque_reached_flag_o)
    else $error("torque flag not cleared");
  AST_TRQ_HOLD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !tick |=> $stable(torque_reached_flag_o))
    else $error("torque flag changed off tick");
  AST_SLOW_STOP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !running_i |=> !slow_speed_flag_o)
    else $error("slow flag while stopped");
  AST_SLOW_ZERO: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    tick && running_i && (low_speed_threshold_i == LSPD_THR_ZERO)
    |=> slow_speed_flag_o == ($past(ctrl_mode_i) == MODE_POSITION))
    else $error("zero threshold slow flag wrong");
  AST_SLOW_ON: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    tick && running_i && (low_speed_threshold_i != LSPD_THR_ZERO) &&
    (ctrl_mode_i != MODE_VF) && (speed_i <= low_speed_threshold_i)
    |=> slow_speed_flag_o)
    else $error("slow flag not set");
  AST_TERM_TRQ: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (output_term_func_sel_a_i == FUNC_TORQUE)
    |=> term_out_o[0] == torque_reached_flag_o)
    else $error("terminal A not torque flag");
  AST_TERM_SLOW: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (output_term_func_sel_d_i == FUNC_LOWSPD)
    |=> term_out_o[3] == slow_speed_flag_o)
    else $error("terminal D not slow flag");
  AST_NOTCH_OFF: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (notch_freq_code_i == NOTCH_OFF) |=> !notch_en_o)
    else $error("notch enabled at code zero");
  AST_FLUX_IGN: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (term1_function_sel_i == TERM1_FLUX_CMD)
    |=> flux_ratio_o == EXC_RATIO_DEF)
    else $error("excitation ratio not ignored");
  AST_SLOW_VF: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    tick && (ctrl_mode_i == MODE_VF) |=> !slow_speed_flag_o)
    else $error("slow flag in V/F mode");
  AST_NOTCH_CTR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (notch_freq_code_i != NOTCH_OFF) |=> notch_en_o &&
    (32'(notch_centre_o) * $past(notch_freq_code_i) <= NOTCH_BASE_DHZ) &&
    (32'(notch_centre_o) * $past(notch_freq_code_i) +
     32'($past(notch_freq_code_i)) > NOTCH_BASE_DHZ))
    else $error("notch centre wrong");
  AST_MON_PASS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    tick && (monitor_filter_tc_i == '0)
    |=> analog_monitor_out_o == $past(monitor_in_i))
    else $error("monitor not passed through");

endmodule : dax_aux

// ==== dax_pkg.sv ====
/*
  Constants shared by the auxiliary detect and notch block of the drive:
  parameter ranges, factory values, terminal function codes, notch tables.
  Assumes a 20 MHz control clock and parameters held in the units noted.
*/
package dax_pkg;

  // ****************************************************************
  // Clock and control cycle
  // ****************************************************************
  localparam int CLK_HZ = 20000000;
  localparam int CTRL_PERIOD_US = 100;
  localparam int CTRL_CYCLES = CLK_HZ / 1000000 * CTRL_PERIOD_US;
  localparam logic [11:0] CTRL_LAST = 12'(CTRL_CYCLES - 1);

  // ****************************************************************
  // Parameter widths, ranges and factory values
  // ****************************************************************
  localparam logic [12:0] ENC_LINES_MAX = 13'h1000;
  localparam logic [12:0] ENC_LINES_DEF = 13'h0800;
  localparam int ENC_MULT = 4;
  localparam logic ENC_DIR_DEF = 1'b1;
  // Excitation ratio in percent
  localparam logic [6:0] EXC_RATIO_DEF = 7'h64;
  localparam logic [6:0] EXC_RATIO_MAX = 7'h64;
  localparam logic [1:0] TERM1_FLUX_CMD = 2'h1;
  localparam logic [4:0] NOTCH_OFF = 5'h00;
  // Torque in percent of rated
  localparam logic [8:0] TRQ_THR_DEF = 9'h096;
  localparam logic [8:0] TRQ_THR_MAX = 9'h190;
  // Speed in r/min
  localparam logic [11:0] LSPD_THR_DEF = 12'h02D;
  localparam logic [11:0] LSPD_THR_MAX = 12'hE10;
  localparam logic [11:0] LSPD_THR_ZERO = 12'h000;
  // Monitor filter time constant in ms
  localparam logic [12:0] MON_TC_DEF = 13'h0032;
  localparam logic [12:0] MON_TC_MAX = 13'h1388;
  localparam int MON_TC_SHIFT_MAX = 15;

  // ****************************************************************
  // Output terminal function codes
  // ****************************************************************
  localparam logic [5:0] FUNC_TORQUE = 6'h23;
  localparam logic [5:0] FUNC_LOWSPD = 6'h22;
  localparam int N_TERMS = 4;

  // Notch centre in 0.1 Hz: 11250 / n
  localparam logic [13:0] NOTCH_BASE_DHZ = 14'h2BF2;

  // Notch depth in dB of attenuation
  localparam logic [5:0] DEPTH_DB_0 = 6'h28;
  localparam logic [5:0] DEPTH_DB_1 = 6'h0E;
  localparam logic [5:0] DEPTH_DB_2 = 6'h08;
  localparam logic [5:0] DEPTH_DB_3 = 6'h04;

  typedef enum logic [1:0] {
    MODE_SPEED,
    MODE_TORQUE,
    MODE_POSITION,
    MODE_VF
  } dax_mode_t;

endpackage : dax_pkg

// ==== dax_motor_model.sv ====
/*
  Behavioural motor with torque, speed and monitor feedback and electromagnetic brake.
  Assumes the bench sets torque, speed and monitor targets as levels.
*/
module dax_motor_model
(
  input wire logic clk_i, // Control clock
  input wire logic [8:0] torque_set_i, // Target torque, percent
  input wire logic [11:0] speed_set_i, // Target speed, r/min
  input wire logic [15:0] mon_set_i, // Target monitor value
  input wire logic brake_release_i, // Brake coil drive
  output logic [8:0] torque_o, // Measured torque
  output logic [11:0] speed_o, // Measured speed
  output logic [15:0] monitor_o, // Raw monitor value
  output logic brake_open_o // Brake released
);
  timeunit 1ns;
  timeprecision 1ns;
  // Feedback changes away from the sampling edge
  always @(negedge clk_i)
  begin
    torque_o <= torque_set_i;
    speed_o <= speed_set_i;
    monitor_o <= mon_set_i;
    brake_open_o <= brake_release_i;
  end
endmodule : dax_motor_model

// ==== testbench.sv ====
/*
  Self-checking bench of the auxiliary detect and notch block.
  Assumes the flags update one cycle after a tick every 2000 clocks.
*/
module testbench;
  import dax_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, arst_n_i = 1'b0;
  logic [12:0] lines = 13'h0000, tc = 13'h0000;
  logic dir = 1'b0, running = 1'b0;
  logic [6:0] exc = 7'h00;
  logic [1:0] term1 = 2'h0, depth = 2'h0, mode = 2'h0;
  logic [4:0] nf = 5'h00;
  logic [8:0] thr = 9'h000, trq_set = 9'h000, trq;
  logic [11:0] lthr = 12'h000, spd_set = 12'h000, spd;
  logic [15:0] mon_set = 16'h0000, mon, amon, mon_old;
  logic [5:0] sel [4] = '{FUNC_TORQUE, FUNC_LOWSPD, FUNC_TORQUE, 6'h00};
  logic [14:0] cnts;
  logic [13:0] centre;
  logic [6:0] flux;
  logic [5:0] atten;
  logic edir, f1, nen, tflag, sflag, brake;
  logic [3:0] term;
  int fails = 0, num_checks = 0;
  logic [31:0] rs = 32'h0000_0049;
  always #25 clk_i = ~clk_i;
  dax_motor_model motor (.clk_i(clk_i), .torque_set_i(trq_set),
    .speed_set_i(spd_set), .mon_set_i(mon_set), .brake_release_i(tflag),
    .torque_o(trq), .speed_o(spd), .monitor_o(mon), .brake_open_o(brake));
  dax_aux dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .encoder_line_count_i(lines), .encoder_dir_sel_i(dir),
    .excitation_ratio_i(exc), .term1_function_sel_i(term1),
    .notch_freq_code_i(nf), .notch_depth_code_i(depth),
    .torque_detect_threshold_i(thr), .low_speed_threshold_i(lthr),
    .monitor_filter_tc_i(tc), .ctrl_mode_i(mode), .running_i(running),
    .torque_i(trq), .speed_i(spd), .monitor_in_i(mon),
    .output_term_func_sel_a_i(sel[0]), .output_term_func_sel_b_i(sel[1]),
    .output_term_func_sel_c_i(sel[2]), .output_term_func_sel_d_i(sel[3]),
    .enc_counts_rev_o(cnts), .enc_dir_o(edir), .flux_ratio_o(flux),
    .flux_from_term1_o(f1), .notch_en_o(nen), .notch_centre_o(centre),
    .notch_atten_db_o(atten), .torque_reached_flag_o(tflag),
    .slow_speed_flag_o(sflag), .term_out_o(term),
    .analog_monitor_out_o(amon));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  function automatic logic [5:0] exp_atten(logic [1:0] c);
    logic [5:0] t [4];
    t = '{6'h28, 6'h0E, 6'h08, 6'h04};
    return t[c];
  endfunction : exp_atten
  function automatic logic [3:0] exp_term(logic t, logic s);
    logic [3:0] r;
    for (int i = 0; i < 4; i++)
      r[i] = (sel[i] == 6'h23) ? t : (sel[i] == 6'h22) ? s : 1'b0;
    return r;
  endfunction : exp_term
  task automatic check(logic [15:0] got, logic [15:0] exp, string what);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  task automatic conclude();
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic tick_wait();
    repeat (2002) @(negedge clk_i);
  endtask : tick_wait
  task automatic flags(logic t, logic s);
    tick_wait();
    check(16'(tflag), 16'(t), "torque flag");
    check(16'(sflag), 16'(s), "slow flag");
    check(16'(term), 16'(exp_term(t, s)), "terminals");
  endtask : flags
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (8) @(negedge clk_i);
    check(16'(cnts), 16'h2000, "reset counts");
    check(16'(edir), 16'h1, "reset dir");
    check(16'(flux), 16'h64, "reset flux");
    check(16'({nen, atten}), 16'h28, "reset notch");
    check(16'({tflag, sflag, term}), 16'h0, "reset flags");
    arst_n_i = 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(negedge clk_i);
      lines = (i == 0) ? 13'h1FFF : 13'(rnd() % 4097);
      dir = 1'(rnd());
      exc = 7'(rnd());
      term1 = 2'(i);
      nf = (i < 32) ? 5'(i) : 5'(rnd());
      depth = 2'(i);
      @(negedge clk_i);
      check(16'(cnts), 16'(((lines > 13'h1000) ? 13'h1000 : lines) * 4),
        "counts");
      check(16'(edir), 16'(dir), "dir");
      check(16'(flux), 16'((term1 == 2'h1 || exc > 7'h64) ? 7'h64 : exc),
        "flux");
      check(16'(f1), 16'(term1 == 2'h1), "flux from terminal 1");
      check(16'(nen), 16'(nf != 5'h00), "notch on");
      if (nf != 5'h00)
        check(16'(centre), 16'(14'h2BF2 / nf), "centre");
      check(16'(atten), 16'(exp_atten(depth)), "depth");
    end
    // Threshold boundaries, brake driven by the torque flag
    sel[3] = 6'h22;
    running = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      thr = (i == 0) ? 9'h000 : (i == 1) ? 9'h190 : 9'(rnd() % 400 + 1);
      lthr = (i == 0) ? 12'hE10 : 12'(rnd() % 3600 + 1);
      trq_set = thr;
      spd_set = lthr;
      flags(1'b1, 1'b1);
      check(16'(brake), 16'h1, "brake open");
      trq_set = thr - 9'h001;
      spd_set = lthr + 12'h001;
      flags(thr == 9'h000, 1'b0);
    end
    spd_set = 12'h000;
    for (int m = 0; m < 4; m++)
    begin
      mode = 2'(m);
      flags(1'b0, m != 3);
    end
    running = 1'b0;
    repeat (2) @(negedge clk_i);
    check(16'(sflag), 16'h0, "stop clears");
    running = 1'b1;
    lthr = 12'h000;
    for (int m = 0; m < 4; m++)
    begin
      mode = 2'(m);
      flags(1'b0, m == 2);
    end
    mon_set = 16'(rnd()) & 16'h7FFF;
    tick_wait();
    check(amon, mon_set, "monitor pass");
    mon_old = mon_set;
    tc = 13'h0032;
    mon_set = 16'hFFFF;
    tick_wait();
    check(16'((amon > mon_old) && (amon != 16'hFFFF)), 16'h0001,
      "monitor smoothed");
    conclude();
  end
  initial
  begin
    #3000000;
    fails++;
    conclude();
  end
endmodule : testbench
